/* bench/sad_dpm_model.sv */
/*
 * Shared-memory partner of the decoder: byte store, RTC in the low 16 bytes.
 * Assumes one request at a time, held by the decoder until this model acks.
 */
`timescale 1ns/100ps
module sad_dpm_model
    import sad_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire sad_dpm_req_t dpm_req,
    input  wire logic [1:0]   lat,
    output logic              dpm_ack,
    output logic [7:0]        dpm_rdata
);
    logic [7:0] mem [int];
    int         wait_n;
    // Data toggles after the ack cycle and while idle (holds during latency waits) so a late sample shows up
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dpm_ack <= 1'b0;
            dpm_rdata <= 8'h00;
            wait_n = 0;
        end else if (dpm_req.req && !dpm_ack && wait_n < lat) begin
            wait_n++;
        end else if (dpm_req.req && !dpm_ack) begin
            wait_n = 0;
            dpm_ack <= 1'b1;
            if (dpm_req.we) mem[dpm_req.idx] = dpm_req.wdata;
            dpm_rdata <= mem.exists(dpm_req.idx) ? mem[dpm_req.idx] : 8'h00;
        end else begin
            dpm_ack <= 1'b0;
            dpm_rdata <= ~dpm_rdata;
        end
    end
endmodule : sad_dpm_model

/* bench/tb_submodule_slave_address_decoder.sv */
/*
 * Self-checking bench of the decoder against a reference kept in integers.
 * Assumes the package constants, a 125 MHz clock and the memory partner.
 */
`timescale 1ns/100ps
module tb_submodule_slave_address_decoder
    import sad_pkg::*;
;
    logic          clk;
    logic          rst_n;
    logic          mode;
    logic          tplug;
    logic          dack;
    logic [1:0]    lat;
    logic [3:0]    evt;
    logic [7:0]    key;
    logic [7:0]    drd;
    logic          attn;
    logic          pwr;
    logic          irq;
    sad_host_req_t req;
    sad_host_rsp_t rsp;
    sad_dpm_req_t  dreq;
    int            fail_count = 0;
    int            n_checks = 0;
    int            attn_n = 0;
    int            attn_m = 0;
    int            waited;
    int            ctrl_m;
    int            flt_m;
    int            st1_m;
    int            pwr_m;
    logic [31:0]   seed = 32'd33520;
    logic [7:0]    mem_m [int];

    sad_decoder dut_u (.clk(clk), .rst_n(rst_n), .host_byte_lane_mode(mode), .host_req(req),
        .host_rsp(rsp), .dpm_req(dreq), .dpm_ack(dack), .dpm_rdata(drd), .test_plug(tplug),
        .key_state(key), .evt_cpu_int(evt[0]), .evt_wdog(evt[1]), .evt_host_rst(evt[2]),
        .evt_glob_rst(evt[3]), .attn_pulse(attn), .pwr_relay(pwr), .host_irq(irq));
    sad_dpm_model part_u (.clk(clk), .rst_n(rst_n), .dpm_req(dreq), .lat(lat),
        .dpm_ack(dack), .dpm_rdata(drd));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (attn === 1'b1) attn_n++;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [7:0] st0();
        logic b5;
        logic b6;
        b5 = |flt_m[3:0];
        b6 = st1_m[7] | st1_m[6];
        return {(b6 & ctrl_m[7]) | (b5 & ctrl_m[6]), b6, b5, tplug, flt_m[3:0]};
    endfunction : st0

    function automatic logic [7:0] exp_of(logic [19:0] off);
        int i;
        i = (off - SAD_OFF_RTC) >> 2;
        if (off < SAD_OFF_REV) return SAD_ID_FILL;
        if (off < SAD_OFF_STAT0) return SAD_REV_FILL;
        if (off == SAD_OFF_STAT0) return st0();
        if (off == SAD_OFF_STAT1) return st1_m[7:0];
        if (off == SAD_OFF_CTRL) return ctrl_m[7:0];
        if (off == SAD_OFF_KEY) return key;
        if (off >= SAD_OFF_RTC) return mem_m.exists(i) ? mem_m[i] : 8'h00;
        return 8'h00;
    endfunction : exp_of

    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic chk(logic [8:0] seen, logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic acc(logic we, logic [19:0] off, logic [7:0] d, logic bad, logic [1:0] lx);
        @(posedge clk);
        #1;
        req.sel = 1'b1;
        req.we = we;
        req.addr = SAD_BASE_ADDR | {12'h000, off} | {30'h0, (mode ? SAD_LANE_BIG : SAD_LANE_LITTLE) ^ lx};
        req.wdata = d;
        req.wpar = ^d ^ ctrl_m[SAD_CTRL_ODD] ^ bad;
        @(posedge clk);
        #1;
        req.sel = 1'b0;
        for (waited = 0; waited < 40 && rsp.ack !== 1'b1; waited++) begin
            @(posedge clk);
            #1;
        end
        if (waited == 40) begin
            fail_count++;
            finish_test();
        end
    endtask : acc

    task automatic wr(logic [19:0] off, logic [7:0] d, logic bad = 1'b0, logic [1:0] lx = 2'h0);
        acc(1'b1, off, d, bad, lx);
        chk({rsp.rpar, rsp.rdata}, {ctrl_m[SAD_CTRL_ODD], 8'h00});
        if (lx != 2'h0 || off == 20'h00400) return;
        if (bad) flt_m[mode ? 3 : 0] = 1'b1;
        else if (off == SAD_OFF_STAT0) flt_m = 0;
        else if (off == SAD_OFF_STAT1) st1_m = 0;
        else if (off == SAD_OFF_CTRL) ctrl_m = d & SAD_CTRL_WMASK;
        else if (off == SAD_OFF_ATTN) attn_m++;
        else if (off == SAD_OFF_PWR) pwr_m = d[SAD_PWR_RELAY];
        else if (off >= SAD_OFF_RTC) mem_m[(off - SAD_OFF_RTC) >> 2] = d;
    endtask : wr

    task automatic rd(logic [19:0] off, logic [1:0] lx = 2'h0);
        logic [7:0] e;
        acc(1'b0, off, 8'h00, 1'b0, lx);
        e = (lx != 2'h0) ? 8'h00 : exp_of(off);
        chk({rsp.rpar, rsp.rdata}, {^e ^ ctrl_m[SAD_CTRL_ODD], e});
        if (off < SAD_OFF_RTC) chk(9'(waited), 9'h000);
    endtask : rd

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        ctrl_m = 0;
        flt_m = 0;
        st1_m = 8'h08;
        pwr_m = 0;
    endtask : do_reset

    initial begin
        logic [19:0] offs [12];
        int          ebit [4];
        logic [16:0] idxq [$];
        offs = '{20'h0, 20'h7c, 20'h80, 20'hfc, SAD_OFF_STAT0, SAD_OFF_STAT1, SAD_OFF_CTRL,
                 SAD_OFF_KEY, SAD_OFF_ATTN, SAD_OFF_PWR, 20'h00400, 20'h00380};
        ebit = '{6, 7, 2, 1};
        req = '0;
        mode = 1'b1;
        tplug = 1'b0;
        lat = 2'h0;
        evt = 4'h0;
        key = 8'h00;
        do_reset();
        key = 8'(rnd());
        tplug = 1'(rnd());
        chk({6'h0, dreq.req, attn, pwr}, 9'h000);
        for (int m = 1; m >= 0; m--) begin
            mode = m[0];
            foreach (offs[i]) rd(offs[i]);
            rd(SAD_OFF_STAT1, 2'h1);
        end
        mode = 1'b1;
        wr(SAD_OFF_CTRL, 8'hff);
        rd(SAD_OFF_CTRL);
        wr(SAD_OFF_ATTN, 8'(rnd()));
        wr(SAD_OFF_ATTN, 8'h00, 1'b1);
        rd(SAD_OFF_STAT0);
        chk(9'(attn_n), 9'(attn_m));
        wr(SAD_OFF_STAT0, 8'h00);
        rd(SAD_OFF_STAT0);
        wr(SAD_OFF_PWR, 8'h80);
        rd(SAD_OFF_KEY);
        chk({8'h0, pwr}, {8'h0, pwr_m[0]});
        wr(SAD_OFF_CTRL, 8'h00, 1'b0, 2'h1);
        wr(20'h00400, 8'h00);
        rd(SAD_OFF_CTRL);
        foreach (ebit[k]) begin
            @(posedge clk);
            #1;
            evt = 4'h1 << k;
            @(posedge clk);
            #1;
            evt = 4'h0;
            st1_m[ebit[k]] = 1'b1;
            rd(SAD_OFF_STAT1);
        end
        rd(SAD_OFF_STAT0);
        chk({8'h0, irq}, {8'h0, ((st1_m[7] | st1_m[6]) & ctrl_m[7]) |
                                ((flt_m[3:0] != 0) & ctrl_m[6])});
        wr(SAD_OFF_STAT1, 8'h00, 1'b1);
        rd(SAD_OFF_STAT1);
        wr(SAD_OFF_STAT1, 8'h00);
        rd(SAD_OFF_STAT1);
        wr(SAD_OFF_RTC + 20'h00008, 8'h96);
        rd(SAD_OFF_RTC + 20'h00008);
        mode = 1'b0;
        idxq = '{17'h0, 17'hf, 17'h10, 17'h1ffff};
        repeat (6) idxq.push_back(17'(rnd()));
        foreach (idxq[i]) begin
            lat = 2'(i);
            wr(SAD_OFF_RTC + {1'b0, idxq[i], 2'b00}, 8'(rnd()));
        end
        wr(SAD_OFF_RTC, 8'h33, 1'b1);
        foreach (idxq[i]) begin
            lat = 2'(i + 1);
            rd(SAD_OFF_RTC + {1'b0, idxq[i], 2'b00});
        end
        rd(SAD_OFF_STAT0);
        do_reset();
        rd(SAD_OFF_CTRL);
        rd(SAD_OFF_STAT1);
        chk({8'h0, pwr}, 9'h000);
        finish_test();
    end
endmodule : tb_submodule_slave_address_decoder

/* hdl/sad_decoder.sv */
/*
 * Slave address decoder and byte-wide register port of the service submodule.
 * Assumes host strobes are synchronous to clk, the shared memory answers
 * with dpm_ack, and the host waits for ack before its next request.
 */
// Behaviour
// R1: In the first position, offsets are decoded from base 0x08000000.
// R2: The block only answers host requests; it never starts a transfer.
// R3: ID area: 32 read-only bytes of board type and serial number.
// R4: Revision area: 32 read-only bytes after the ID area.
// R5: Direct byte registers: status pair, control, attention, power-down, key switch.
// R6: Real-time-clock registers are the lower 16 shared-memory locations.
// R7: A 128k-byte shared memory follows, reached through the memory port.
// R8: Every access is one byte on the low host data lanes.
// R9: Host forms addresses matching the selected byte-lane mode.
// R10: Write parity is checked, read parity is generated, per addressed lane.
// R11: Direct registers answer in hardware with no local processor involvement.
// R12: Commands and bulk data travel through the shared memory.
// R13: Clearable status flags clear on a host write to their address.
// R14: Attention write needs good parity; only the write event counts.
// R15: Control and power-down bits are low after reset.
// R16: Unmapped accesses change no state; read data there is meaningless.
`timescale 1ns/100ps
module sad_decoder
    import sad_pkg::*;
#(
    parameter logic [SAD_PROM_BYTES*8-1:0] ID_PROM  = {SAD_PROM_BYTES{SAD_ID_FILL}},
    parameter logic [SAD_PROM_BYTES*8-1:0] REV_PROM = {SAD_PROM_BYTES{SAD_REV_FILL}}
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          host_byte_lane_mode,
    input  wire sad_host_req_t host_req,
    output sad_host_rsp_t      host_rsp,
    output sad_dpm_req_t       dpm_req,
    input  wire logic          dpm_ack,
    input  wire logic [7:0]    dpm_rdata,
    input  wire logic          test_plug,
    input  wire logic [7:0]    key_state,
    input  wire logic          evt_cpu_int,
    input  wire logic          evt_wdog,
    input  wire logic          evt_host_rst,
    input  wire logic          evt_glob_rst,
    output logic               attn_pulse,
    output logic               pwr_relay,
    output logic               host_irq
);

    // ----------------------------------------------------------------
    // Decode and parity helpers
    // ----------------------------------------------------------------
    function automatic sad_dec_t sad_decode(input logic [31:0] a, input logic lane_mode_flag);
        sad_dec_t    d;
        logic [19:0] off;
        logic [19:0] rel;
        d.region = RG_NONE;
        d.idx    = '0;
        off      = {a[SAD_WIN_W-1:2], 2'b00};
        rel      = off - SAD_OFF_RTC;
        if (a[31:SAD_WIN_W] == SAD_BASE_ADDR[31:SAD_WIN_W] &&
            a[1:0] == (lane_mode_flag ? SAD_LANE_BIG : SAD_LANE_LITTLE)) begin
            if (off < SAD_OFF_REV) begin
                d.region = RG_ID;
                d.idx    = {12'h000, off[6:2]};
            end else if (off < SAD_OFF_STAT0) begin
                d.region = RG_REV;
                d.idx    = {12'h000, off[6:2]};
            end else if (off >= SAD_OFF_RTC && rel[19:2] < SAD_MEM_DEPTH) begin
                d.region = RG_MEM;
                d.idx    = rel[18:2];
            end else begin
                case (off)
                    SAD_OFF_STAT0: d.region = RG_STAT0;
                    SAD_OFF_STAT1: d.region = RG_STAT1;
                    SAD_OFF_CTRL:  d.region = RG_CTRL;
                    SAD_OFF_ATTN:  d.region = RG_ATTN;
                    SAD_OFF_PWR:   d.region = RG_PWR;
                    SAD_OFF_KEY:   d.region = RG_KEY;
                    default:       d.region = RG_NONE;
                endcase
            end
        end
        return d;
    endfunction : sad_decode

    // Parity bit that makes the byte plus parity match the selected sense
    function automatic logic sad_par(input logic [7:0] d, input logic odd);
        return odd ? ~(^d) : ^d;
    endfunction : sad_par

    typedef enum logic {ST_IDLE, ST_MEM} sad_state_t;

    sad_state_t    state_q;
    sad_host_rsp_t rsp_q;
    sad_dpm_req_t  dpm_q;
    logic [7:0]    ctrl_q;
    logic [7:0]    st1_q;
    logic [3:0]    perr_q;
    logic          pwr_q;
    logic          attn_q;
    logic          irq_q;

    sad_dec_t      dec;
    logic          take;
    logic          par_ok;
    logic          wr_ok;
    logic          wr_bad;
    logic          pend_intr;
    logic          pend_perr;
    logic          irq_d;
    logic [7:0]    rd_d;
    logic [7:0]    st1_set;

    assign dec       = sad_decode(host_req.addr, host_byte_lane_mode); // R1
    // Only a host strobe starts work; requests during a memory wait are ignored
    assign take      = host_req.sel && state_q == ST_IDLE; // R2
    assign par_ok    = sad_par(host_req.wdata, ctrl_q[SAD_CTRL_ODD]) == host_req.wpar; // R10
    assign wr_ok     = take && host_req.we && par_ok;
    assign wr_bad    = take && host_req.we && !par_ok && dec.region != RG_NONE; // R16
    assign pend_intr = st1_q[SAD_ST1_WDOG] | st1_q[SAD_ST1_CPU];
    assign pend_perr = |perr_q;
    assign irq_d     = (pend_intr & ctrl_q[SAD_CTRL_INTRENA]) |
                       (pend_perr & ctrl_q[SAD_CTRL_PFINTENA]);

    assign st1_set = {evt_wdog, evt_cpu_int, 2'b00, 1'b0,
                      evt_host_rst, evt_glob_rst, 1'b0};

    // ----------------------------------------------------------------
    // Read data mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_d = '0;
        unique case (dec.region)
            RG_ID:    rd_d = ID_PROM[dec.idx[4:0]*8 +: 8];  // R3
            RG_REV:   rd_d = REV_PROM[dec.idx[4:0]*8 +: 8]; // R4
            RG_STAT0: rd_d = {irq_d, pend_intr, pend_perr, test_plug, perr_q}; // R5
            RG_STAT1: rd_d = st1_q;                         // R5
            RG_CTRL:  rd_d = ctrl_q;                        // R5
            RG_KEY:   rd_d = key_state;                     // R5
            RG_ATTN, RG_PWR, RG_MEM, RG_NONE: rd_d = '0;    // R16
        endcase
    end

    // ----------------------------------------------------------------
    // Transfer sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else if (take && dec.region == RG_MEM && (!host_req.we || par_ok)) begin
            state_q <= ST_MEM;
        end else if (state_q == ST_MEM && dpm_ack) begin
            state_q <= ST_IDLE;
        end
    end

    // Memory request holds until the shared memory answers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dpm_q <= '0;
        end else if (take && dec.region == RG_MEM && (!host_req.we || par_ok)) begin
            dpm_q.req   <= 1'b1;             // R12
            dpm_q.we    <= host_req.we;      // R7
            dpm_q.idx   <= dec.idx;          // R6
            dpm_q.wdata <= host_req.wdata;   // R8
        end else if (state_q == ST_MEM && dpm_ack) begin
            dpm_q.req   <= 1'b0;
        end
    end

    // Direct regions and bad-parity memory writes answer next cycle; other memory accesses answer after dpm_ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else if (take && !(dec.region == RG_MEM && (!host_req.we || par_ok))) begin
            rsp_q.ack   <= 1'b1;                                     // R11
            rsp_q.rdata <= host_req.we ? 8'h00 : rd_d;               // R8
            rsp_q.rpar  <= sad_par(host_req.we ? 8'h00 : rd_d,
                                   ctrl_q[SAD_CTRL_ODD]);            // R10
        end else if (state_q == ST_MEM && dpm_ack) begin
            rsp_q.ack   <= 1'b1;
            rsp_q.rdata <= dpm_q.we ? 8'h00 : dpm_rdata;
            rsp_q.rpar  <= sad_par(dpm_q.we ? 8'h00 : dpm_rdata,
                                   ctrl_q[SAD_CTRL_ODD]);            // R10
        end else begin
            rsp_q.ack   <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Direct registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= SAD_CTRL_RESET;                                // R15
        end else if (wr_ok && dec.region == RG_CTRL) begin
            ctrl_q <= host_req.wdata & SAD_CTRL_WMASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= 1'b0;                                           // R15
        end else if (wr_ok && dec.region == RG_PWR) begin
            pwr_q <= host_req.wdata[SAD_PWR_RELAY];
        end
    end

    // Bad parity raises no attention, so a corrupted write cannot wake the CPU
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            attn_q <= 1'b0;
        end else begin
            attn_q <= wr_ok && dec.region == RG_ATTN;                // R14
        end
    end

    // Set wins over the clear so an event in the clearing cycle survives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st1_q <= SAD_ST1_RESET;
        end else if (wr_ok && dec.region == RG_STAT1) begin
            st1_q <= st1_set;                                        // R13
        end else begin
            st1_q <= st1_q | st1_set;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perr_q <= '0;
        end else begin
            perr_q <= ((wr_ok && dec.region == RG_STAT0) ? 4'h0 : perr_q) |
                      (wr_bad ? (4'h1 << host_req.addr[1:0]) : 4'h0); // R13 R10
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign host_rsp   = rsp_q;
    assign dpm_req    = dpm_q;
    assign attn_pulse = attn_q;
    assign pwr_relay  = pwr_q;
    assign host_irq   = irq_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_mem_issue;
        take && dec.region == RG_MEM && !host_req.we;
    endsequence
    sequence s_mem_done;
        state_q == ST_MEM && dpm_ack;
    endsequence

    property p_base_decode;
        take && host_req.addr[31:SAD_WIN_W] != SAD_BASE_ADDR[31:SAD_WIN_W]
            |-> dec.region == RG_NONE;
    endproperty
    a_base_decode: assert property (p_base_decode) // R1
        else $error("foreign base address decoded");

    property p_direct_ack;
        take && dec.region != RG_MEM |=> host_rsp.ack && !dpm_req.req;
    endproperty
    a_direct_ack: assert property (p_direct_ack) // R11
        else $error("direct access not answered next cycle");

    property p_mem_issue;
        s_mem_issue |=> dpm_req.req && !dpm_req.we && !host_rsp.ack;
    endproperty
    a_mem_issue: assert property (p_mem_issue) // R12
        else $error("memory read not forwarded");

    property p_mem_done;
        s_mem_done |=> host_rsp.ack && !dpm_req.req && state_q == ST_IDLE;
    endproperty
    a_mem_done: assert property (p_mem_done) // R7
        else $error("memory answer not returned");

    property p_rd_parity;
        host_rsp.ack |-> host_rsp.rpar == sad_par(host_rsp.rdata, $past(ctrl_q[SAD_CTRL_ODD]));
    endproperty
    a_rd_parity: assert property (p_rd_parity) // R10
        else $error("read parity wrong");

    property p_perr_flag;
        wr_bad |=> perr_q[$past(host_req.addr[1:0])] && pend_perr;
    endproperty
    a_perr_flag: assert property (p_perr_flag) // R10
        else $error("parity fault not recorded");

    property p_st0_clear;
        wr_ok && dec.region == RG_STAT0 |=> perr_q == 4'h0;
    endproperty
    a_st0_clear: assert property (p_st0_clear) // R13
        else $error("status flags not cleared by write");

    property p_attn_pulse;
        take && host_req.we && dec.region == RG_ATTN
            |=> attn_pulse == $past(par_ok) ##1 !attn_pulse;
    endproperty
    a_attn_pulse: assert property (p_attn_pulse) // R14
        else $error("attention pulse wrong");

    property p_unmapped;
        take && dec.region == RG_NONE
            |=> $stable(ctrl_q) && $stable(pwr_q) && !dpm_req.req && !attn_pulse;
    endproperty
    a_unmapped: assert property (p_unmapped) // R16
        else $error("unmapped access changed state");

endmodule : sad_decoder

/* hdl/sad_pkg.sv */
/*
 * Constants and carrier types of the submodule slave address decoder.
 * Assumes byte offsets are seen within a 1 MB submodule window.
 */
package sad_pkg;

    // ----------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------
    localparam logic [31:0] SAD_BASE_ADDR   = 32'h0800_0000;
    localparam int          SAD_WIN_W       = 20;
    localparam logic [1:0]  SAD_LANE_BIG    = 2'h3;
    localparam logic [1:0]  SAD_LANE_LITTLE = 2'h0;
    localparam logic [19:0] SAD_OFF_ID      = 20'h00000;
    localparam logic [19:0] SAD_OFF_REV     = 20'h00080;
    localparam logic [19:0] SAD_OFF_STAT0   = 20'h00100;
    localparam logic [19:0] SAD_OFF_STAT1   = 20'h00104;
    localparam logic [19:0] SAD_OFF_CTRL    = 20'h00180;
    localparam logic [19:0] SAD_OFF_ATTN    = 20'h00200;
    localparam logic [19:0] SAD_OFF_PWR     = 20'h00280;
    localparam logic [19:0] SAD_OFF_KEY     = 20'h00300;
    localparam logic [19:0] SAD_OFF_RTC     = 20'h20000;
    localparam logic [19:0] SAD_OFF_DPM     = 20'h20040;
    localparam logic [17:0] SAD_MEM_DEPTH   = 18'h20000;
    localparam int          SAD_PROM_BYTES  = 32;

    // ----------------------------------------------------------------
    // Register fields and reset values
    // ----------------------------------------------------------------
    localparam int         SAD_CTRL_INTRENA  = 7;
    localparam int         SAD_CTRL_PFINTENA = 6;
    localparam int         SAD_CTRL_ODD      = 5;
    localparam logic [7:0] SAD_CTRL_WMASK    = 8'he0;
    localparam int         SAD_PWR_RELAY     = 7;
    localparam int         SAD_ST1_WDOG      = 7;
    localparam int         SAD_ST1_CPU       = 6;
    localparam int         SAD_ST1_PWRON     = 3;
    localparam int         SAD_ST1_BRST      = 2;
    localparam int         SAD_ST1_GRST      = 1;
    localparam logic [7:0] SAD_ST1_RESET     = 8'h08;
    localparam logic [7:0] SAD_CTRL_RESET    = 8'h00;
    // Arbitrary PROM fill values, not real identification codes
    localparam logic [7:0] SAD_ID_FILL       = 8'h5a;
    localparam logic [7:0] SAD_REV_FILL      = 8'h01;

    typedef enum logic [3:0] {
        RG_NONE, RG_ID, RG_REV, RG_STAT0, RG_STAT1,
        RG_CTRL, RG_ATTN, RG_PWR, RG_KEY, RG_MEM
    } sad_region_t;

    typedef struct packed {
        logic        sel;
        logic        we;
        logic [31:0] addr;
        logic [7:0]  wdata;
        logic        wpar;
    } sad_host_req_t;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
        logic       rpar;
    } sad_host_rsp_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [16:0] idx;
        logic [7:0]  wdata;
    } sad_dpm_req_t;

    typedef struct packed {
        sad_region_t region;
        logic [16:0] idx;
    } sad_dec_t;

endpackage : sad_pkg
